// File: sar_adc_defines.vh
// Register map, field positions, reset values and timing counts of the ADC sequencer
`ifndef SAR_ADC_DEFINES_VH
`define SAR_ADC_DEFINES_VH

// Register byte offsets
`define OFS_CONTROL        8'h00
`define OFS_CONFIG         8'h04
`define OFS_ACCUM_CFG      8'h08
`define OFS_RESULT_LOW     8'h0C
`define OFS_RESULT_HIGH    8'h10
`define OFS_STATUS         8'h14

// Control register fields
`define CTL_BUSY           0
`define CTL_EOC            1
`define CTL_LPT            2
`define CTL_MODE_LSB       4
`define CTL_MODE_MSB       6
`define CTL_ENABLE         7
`define CTL_BURST          8

// Accumulator config fields
`define ACC_RPT_LSB        0
`define ACC_RPT_MSB        2
`define ACC_SJ_LSB         3
`define ACC_SJ_MSB         5

// Start mode encodings
`define MODE_SOFTWARE      3'h0
`define MODE_TIMER0        3'h1
`define MODE_TIMER2        3'h2
`define MODE_TIMER3        3'h3
`define MODE_EXTERNAL      3'h4

// Reset values
`define RST_DIVIDER        5'h1F
`define RST_REPEAT         3'h0
`define RST_JUSTIFY        3'h0

// Timing in divider ticks, two per conversion-clock cycle
`define LPT_TRACK_CLKS     4'h3
`define CONV_CLKS          4'hB
`define PWRUP_CLKS         4'h4

`endif

// File: sar_clock_divider.v
// Conversion clock divider with selectable system or low-power oscillator source
`timescale 1ns/1ps

module sar_clock_divider #(
    parameter DIV_W = 5
) (
    // Clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // Source selection and ratio
    input  wire             use_lpo,
    input  wire             lpo_osc,
    input  wire [DIV_W-1:0] div_field,
    // Conversion clock
    output reg              sar_tick_ff,
    output reg              conversion_clock_ff
);

    reg              lpo_s1_ff;
    reg              lpo_s2_ff;
    reg              lpo_s3_ff;
    reg [DIV_W-1:0]  cnt_ff;
    reg [DIV_W-1:0]  nxt_cnt;
    wire             src_tick;

    // Oscillator arrives from its own domain; only its edges are used
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lpo_s1_ff <= 1'b0;
            lpo_s2_ff <= 1'b0;
            lpo_s3_ff <= 1'b0;
        end
        else
        begin
            lpo_s1_ff <= lpo_osc;
            lpo_s2_ff <= lpo_s1_ff;
            lpo_s3_ff <= lpo_s2_ff;
        end
    end

    // Source pick: system clock or oscillator edge
    assign src_tick = use_lpo ? (lpo_s2_ff & ~lpo_s3_ff) : 1'b1;

    // Divide by field plus one
    always @*
    begin
        nxt_cnt = cnt_ff;
        if (src_tick)
        begin
            if (cnt_ff >= div_field)
                nxt_cnt = {DIV_W{1'b0}};
            else
                nxt_cnt = cnt_ff + {{(DIV_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_ff      <= {DIV_W{1'b0}};
            sar_tick_ff <= 1'b0;
            conversion_clock_ff  <= 1'b0;
        end
        else
        begin
            cnt_ff      <= nxt_cnt;
            sar_tick_ff <= src_tick && (cnt_ff >= div_field);
            if (src_tick && (cnt_ff >= div_field))
                conversion_clock_ff <= ~conversion_clock_ff;
        end
    end

endmodule // sar_clock_divider

// File: sar_adc_sequencer.v
// SAR ADC start select, track/convert sequencer, accumulator and APB register file
`timescale 1ns/1ps
`include "sar_adc_defines.vh"

module sar_adc_sequencer #(
    parameter DIV_W  = 5,
    parameter CODE_W = 10
) (
    // Clock and reset
    input  wire              pclk,
    input  wire              presetn,
    // APB slave
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [7:0]        paddr,
    input  wire [31:0]       pwdata,
    output wire              pready,
    output wire              pslverr,
    output reg  [31:0]       prdata,
    // Start sources
    input  wire              timer0_ovf,
    input  wire              timer2_low_ovf,
    input  wire              timer2_high_ovf,
    input  wire              timer2_split,
    input  wire              timer3_low_ovf,
    input  wire              timer3_high_ovf,
    input  wire              timer3_split,
    input  wire              external_convert_start,
    // Clocking and power state
    input  wire              lpo_osc,
    input  wire              standby_req,
    // Analog core
    input  wire [CODE_W-1:0] sar_code,
    output wire              conversion_clock,
    output reg               sar_track_ff,
    output reg               sar_convert_ff,
    output reg               sar_power_ff,
    output reg               conversion_done_ff
);

    localparam ST_IDLE  = 3'h0;
    localparam ST_PWRUP = 3'h1;
    localparam ST_TRACK = 3'h2;
    localparam ST_CONV  = 3'h3;
    localparam ST_DONE  = 3'h4;

    // Registers
    reg              busy_ff;
    reg              eoc_ff;
    reg              lpt_ff;
    reg [2:0]        mode_ff;
    reg              enable_ff;
    reg              burst_ff;
    reg [DIV_W-1:0]  div_ff;
    reg [2:0]        repeat_ff;
    reg [2:0]        justify_ff;
    reg [15:0]       result_ff;
    // Sequencer
    reg [2:0]        state_ff;
    reg [2:0]        nxt_state;
    reg [3:0]        clk_cnt_ff;
    reg [6:0]        sample_cnt_ff;
    reg [15:0]       acc_ff;
    reg [15:0]       sum;
    reg [15:0]       formatted;
    reg [6:0]        repeat_target;
    reg              cnv_s1_ff;
    reg              cnv_s2_ff;
    reg              cnv_s3_ff;
    reg              trigger;

    wire             sar_tick;
    wire             setup_phase;
    wire             wr_access;
    wire             mapped;
    wire             cnv_rise;
    wire             t2_ovf;
    wire             t3_ovf;
    wire             sw_start;
    wire             start_evt;
    wire             last_sample;
    wire             ext_lpt;

    // Conversion clock, oscillator only while in burst
    sar_clock_divider #(
        .DIV_W       (DIV_W)
    ) u_div (
        .pclk        (pclk),
        .presetn     (presetn),
        .use_lpo     (burst_ff),
        .lpo_osc     (lpo_osc),
        .div_field   (div_ff),
        .sar_tick_ff (sar_tick),
        .conversion_clock_ff  (conversion_clock)
    );

    // APB decode; the slave never waits
    assign pready      = 1'b1;
    assign setup_phase = psel && !penable;
    assign wr_access   = psel && penable && pwrite;
    assign mapped      = (paddr == `OFS_CONTROL)    || (paddr == `OFS_CONFIG) ||
                         (paddr == `OFS_ACCUM_CFG)  || (paddr == `OFS_RESULT_LOW) ||
                         (paddr == `OFS_RESULT_HIGH) || (paddr == `OFS_STATUS);
    assign pslverr     = psel && penable && !mapped;

    // Start pin comes from outside: two flops before any logic
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnv_s1_ff <= 1'b0;
            cnv_s2_ff <= 1'b0;
            cnv_s3_ff <= 1'b0;
        end
        else
        begin
            cnv_s1_ff <= external_convert_start;
            cnv_s2_ff <= cnv_s1_ff;
            cnv_s3_ff <= cnv_s2_ff;
        end
    end

    assign cnv_rise = cnv_s2_ff && !cnv_s3_ff;
    assign t2_ovf   = timer2_split ? timer2_low_ovf : timer2_high_ovf;
    assign t3_ovf   = timer3_split ? timer3_low_ovf : timer3_high_ovf;
    assign sw_start = wr_access && (paddr == `OFS_CONTROL) && pwdata[`CTL_BUSY];

    // At most one source feeds the sequencer; mode codes above 4 feed none
    always @*
    begin
        case (mode_ff)
            `MODE_SOFTWARE: trigger = sw_start;
            `MODE_TIMER0:   trigger = timer0_ovf;
            `MODE_TIMER2:   trigger = t2_ovf;
            `MODE_TIMER3:   trigger = t3_ovf;
            `MODE_EXTERNAL: trigger = cnv_rise;
            default:        trigger = 1'b0;
        endcase
    end

    // Starts arriving mid-conversion are dropped, not queued
    assign start_evt = trigger && (state_ff == ST_IDLE);
    assign ext_lpt   = lpt_ff && (mode_ff == `MODE_EXTERNAL);

    // Repeat field to sample count; codes above 101 act as one
    always @*
    begin
        case (repeat_ff)
            3'h1:    repeat_target = 7'h04;
            3'h2:    repeat_target = 7'h08;
            3'h3:    repeat_target = 7'h10;
            3'h4:    repeat_target = 7'h20;
            3'h5:    repeat_target = 7'h40;
            default: repeat_target = 7'h01;
        endcase
    end

    assign last_sample = (sample_cnt_ff + 7'h01) >= repeat_target;

    // 64 x 1023 fits in 16 bits, so no overflow guard
    always @*
    begin
        sum = acc_ff + {{(16-CODE_W){1'b0}}, sar_code};
    end

    // Result formatting; unused positions stay zero
    always @*
    begin
        if (justify_ff[2])
            formatted = {sum[CODE_W-1:0], {(16-CODE_W){1'b0}}};
        else
            formatted = sum >> justify_ff[1:0];
    end

    // Sequencer next state
    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (start_evt)
                begin
                    if (burst_ff && !enable_ff)
                        nxt_state = ST_PWRUP;
                    else if (ext_lpt)
                        nxt_state = ST_CONV;
                    else if (lpt_ff || burst_ff)
                        nxt_state = ST_TRACK;
                    else
                        nxt_state = ST_CONV;
                end
            end
            ST_PWRUP:
            begin
                if (sar_tick && (clk_cnt_ff == `PWRUP_CLKS - 4'h1))
                    nxt_state = ext_lpt ? ST_CONV : ST_TRACK;
            end
            ST_TRACK:
            begin
                if (sar_tick && (clk_cnt_ff == `LPT_TRACK_CLKS - 4'h1))
                    nxt_state = ST_CONV;
            end
            ST_CONV:
            begin
                if (sar_tick && (clk_cnt_ff == `CONV_CLKS - 4'h1))
                    nxt_state = ST_DONE;
            end
            ST_DONE:
            begin
                // Burst chains the series without a new start
                if (burst_ff && !last_sample)
                    nxt_state = (lpt_ff && !ext_lpt) ? ST_TRACK : ST_CONV;
                else
                    nxt_state = ST_IDLE;
            end
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    // Sequencer state, counters and accumulator
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff      <= ST_IDLE;
            clk_cnt_ff    <= 4'h0;
            sample_cnt_ff <= 7'h00;
            acc_ff        <= 16'h0000;
            result_ff     <= 16'h0000;
        end
        else
        begin
            state_ff <= nxt_state;
            if (nxt_state != state_ff)
                clk_cnt_ff <= 4'h0;
            else if (sar_tick)
                clk_cnt_ff <= clk_cnt_ff + 4'h1;
            if (start_evt && (sample_cnt_ff == 7'h00))
                acc_ff <= 16'h0000;
            if (state_ff == ST_DONE)
            begin
                if (last_sample)
                begin
                    result_ff     <= formatted;
                    acc_ff        <= 16'h0000;
                    sample_cnt_ff <= 7'h00;
                end
                else
                begin
                    acc_ff        <= sum;
                    sample_cnt_ff <= sample_cnt_ff + 7'h01;
                end
            end
        end
    end

    // Analog core controls, registered
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sar_track_ff       <= 1'b0;
            sar_convert_ff     <= 1'b0;
            sar_power_ff       <= 1'b0;
            conversion_done_ff <= 1'b0;
        end
        else
        begin
            sar_convert_ff     <= (nxt_state == ST_CONV);
            conversion_done_ff <= (state_ff == ST_DONE) && last_sample;
            // Burst powers only while active unless enable keeps it up
            sar_power_ff       <= burst_ff ? (enable_ff || (nxt_state != ST_IDLE))
                                           : enable_ff;
            if (standby_req)
                sar_track_ff <= 1'b0;
            else if (nxt_state == ST_TRACK)
                sar_track_ff <= 1'b1;
            else if (nxt_state == ST_IDLE && ext_lpt)
                sar_track_ff <= enable_ff && !cnv_s2_ff;
            else if (nxt_state == ST_IDLE)
                sar_track_ff <= enable_ff && !lpt_ff && !burst_ff;
            else
                sar_track_ff <= 1'b0;
        end
    end

    // Control and configuration registers
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_ff    <= 1'b0;
            eoc_ff     <= 1'b0;
            lpt_ff     <= 1'b0;
            mode_ff    <= `MODE_SOFTWARE;
            enable_ff  <= 1'b0;
            burst_ff   <= 1'b0;
            div_ff     <= `RST_DIVIDER;
            repeat_ff  <= `RST_REPEAT;
            justify_ff <= `RST_JUSTIFY;
        end
        else
        begin
            if (wr_access && (paddr == `OFS_CONTROL))
            begin
                lpt_ff    <= pwdata[`CTL_LPT];
                mode_ff   <= pwdata[`CTL_MODE_MSB:`CTL_MODE_LSB];
                enable_ff <= pwdata[`CTL_ENABLE];
                burst_ff  <= pwdata[`CTL_BURST];
            end
            if (wr_access && (paddr == `OFS_CONFIG))
                div_ff <= pwdata[DIV_W-1:0];
            if (wr_access && (paddr == `OFS_ACCUM_CFG))
            begin
                repeat_ff  <= pwdata[`ACC_RPT_MSB:`ACC_RPT_LSB];
                justify_ff <= pwdata[`ACC_SJ_MSB:`ACC_SJ_LSB];
            end
            // Busy spans the burst, or one conversion outside burst
            if (start_evt)
                busy_ff <= 1'b1;
            else if (state_ff == ST_DONE && (!burst_ff || last_sample))
                busy_ff <= 1'b0;
            // Hardware set beats a software clear in the same cycle
            if (state_ff == ST_DONE && last_sample)
                eoc_ff <= 1'b1;
            else if (wr_access && (paddr == `OFS_CONTROL) && !pwdata[`CTL_EOC])
                eoc_ff <= 1'b0;
        end
    end

    // Read data captured in setup, held through access
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (setup_phase && !pwrite)
        begin
            case (paddr)
                `OFS_CONTROL:     prdata <= {23'h000000, burst_ff, enable_ff, mode_ff,
                                             1'b0, lpt_ff, eoc_ff, busy_ff};
                `OFS_CONFIG:      prdata <= {{(32-DIV_W){1'b0}}, div_ff};
                `OFS_ACCUM_CFG:   prdata <= {26'h0000000, justify_ff, repeat_ff};
                `OFS_RESULT_LOW:  prdata <= {24'h000000, result_ff[7:0]};
                `OFS_RESULT_HIGH: prdata <= {24'h000000, result_ff[15:8]};
                `OFS_STATUS:      prdata <= {26'h0000000, sar_power_ff, sar_convert_ff,
                                             sar_track_ff, state_ff};
                default:          prdata <= 32'h00000000;
            endcase
        end
    end

endmodule // sar_adc_sequencer

// File: sar_adc_checker.sv
// Port-level assertions for the ADC sequencer
`timescale 1ns/1ps

module sar_adc_checker (
    // Clock, reset and bus
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire [7:0]  paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // Core side
    input wire        standby_req,
    input wire        sar_track_ff,
    input wire        sar_convert_ff,
    input wire        conversion_done_ff
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Zero-wait bus, error only on unmapped places
    AST_NO_WAIT: assert property (pready) else $error("pready low");
    AST_UNMAPPED: assert property (psel && penable && paddr == 8'h18 |-> pslverr)
        else $error("no error on unmapped access");
    AST_MAPPED: assert property (psel && penable && paddr == 8'h04 |-> !pslverr)
        else $error("error on mapped access");
    AST_READ_HOLD: assert property (psel && penable |=> $stable(prdata))
        else $error("read data moved during access");
    // Completion is one short pulse that follows a conversion
    AST_DONE_PULSE: assert property (conversion_done_ff |=> !conversion_done_ff [*8])
        else $error("done pulse too long or too close");
    AST_DONE_CAUSE: assert property ($rose(conversion_done_ff) |->
        $past(sar_convert_ff) || $past(sar_convert_ff, 2)) else $error("done without conversion");
    AST_CONV_MIN: assert property ($rose(sar_convert_ff) |-> sar_convert_ff [*8])
        else $error("conversion cut short");
    // Tracking never overlaps converting, and stops in standby
    AST_TRACK_EXCL: assert property (!(sar_track_ff && sar_convert_ff))
        else $error("tracking while converting");
    AST_STANDBY: assert property (standby_req [*2] |-> !sar_track_ff)
        else $error("tracking in standby");
endmodule // sar_adc_checker

bind sar_adc_sequencer sar_adc_checker u_sar_adc_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .standby_req(standby_req),
    .sar_track_ff(sar_track_ff), .sar_convert_ff(sar_convert_ff),
    .conversion_done_ff(conversion_done_ff));

// File: sar_core_model.sv
// Behavioural analog core and timer overflow source
`timescale 1ns/1ps

module sar_core_model (
    // Clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // Bench controls
    input  wire [9:0] level,
    input  wire [4:0] fire,
    // Sequencer side
    input  wire       sar_convert_ff,
    output reg  [9:0] sar_code,
    output reg  [4:0] ovf_ff
);
    reg       conv_d_ff;
    reg [9:0] junk_ff;

    // Overflows are one-cycle pulses; junk flips so no stale code survives
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            conv_d_ff <= 1'h0;
            junk_ff   <= 10'h155;
            ovf_ff    <= 5'h00;
        end
        else
        begin
            conv_d_ff <= sar_convert_ff;
            junk_ff   <= ~junk_ff;
            ovf_ff    <= fire;
        end
    end

    // Code valid only while converting and one cycle after
    always @*
        sar_code = (sar_convert_ff || conv_d_ff) ? level : junk_ff;
endmodule // sar_core_model

// File: tb_sar_adc_sequencer.sv
// Self-checking bench for the ADC sequencer
`timescale 1ns/1ps
`include "sar_adc_defines.vh"

module tb_sar_adc_sequencer;
    reg         pclk, presetn, psel, penable, pwrite;
    reg         err, split, pin, lpo, standby, prv;
    reg  [7:0]  paddr;
    reg  [31:0] pwdata, rd;
    reg  [9:0]  level;
    reg  [4:0]  fire;
    reg  [31:0] rows [0:8];
    reg  [9:0]  srcs [0:5];
    reg  [15:0] prev;
    wire        pready, pslverr, conversion_clock, trk, cnv, pwr, done;
    wire [31:0] prdata;
    wire [9:0]  sar_code;
    wire [4:0]  ovf;
    integer     miscompares, comparisons, i, k, n;

    // System clock, 20 MHz
    initial
    begin
        pclk = 1'h0;
        forever #25 pclk = ~pclk;
    end

    // Free low-power oscillator, unrelated in phase
    initial
    begin
        lpo = 1'h0;
        forever #85 lpo = ~lpo;
    end

    // Design and far side
    sar_adc_sequencer u_sar_adc_sequencer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .timer0_ovf(ovf[0]), .timer2_low_ovf(ovf[1]), .timer2_high_ovf(ovf[2]),
        .timer2_split(split), .timer3_low_ovf(ovf[3]), .timer3_high_ovf(ovf[4]),
        .timer3_split(split), .external_convert_start(pin), .lpo_osc(lpo),
        .standby_req(standby), .sar_code(sar_code), .conversion_clock(conversion_clock), .sar_track_ff(trk),
        .sar_convert_ff(cnv), .sar_power_ff(pwr), .conversion_done_ff(done));
    sar_core_model u_sar_core_model (
        .pclk(pclk), .presetn(presetn), .level(level), .fire(fire),
        .sar_convert_ff(cnv), .sar_code(sar_code), .ovf_ff(ovf));

    task test_done;
        begin
            $display("comparisons %0d miscompares %0d", comparisons, miscompares);
            if (miscompares == 0 && comparisons > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    task chk(input [31:0] seen, input [31:0] exp, input [8*8-1:0] what);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp)
            begin
                miscompares = miscompares + 1;
                $display("BAD %0s exp %h seen %h", what, exp, seen);
            end
        end
    endtask

    // One APB transfer; request held until pready is seen
    task apb(input w, input [7:0] a, input [31:0] d);
        integer j;
        begin
            @(posedge pclk);
            psel    <= 1'h1;
            pwrite  <= w;
            paddr   <= a;
            pwdata  <= d;
            @(posedge pclk);
            penable <= 1'h1;
            @(posedge pclk);
            for (j = 0; pready !== 1'h1 && j < 20; j = j + 1)
                @(posedge pclk);
            rd      = prdata;
            err     = pslverr;
            psel    <= 1'h0;
            penable <= 1'h0;
            if (j == 20)
            begin
                miscompares = miscompares + 1;
                test_done;
            end
        end
    endtask

    // Poll a control bit until it reaches a value, bounded
    task poll(input integer b, input v);
        begin
            n = 0;
            apb(1'h0, `OFS_CONTROL, 32'h0);
            while (rd[b] !== v && n < 300)
            begin
                apb(1'h0, `OFS_CONTROL, 32'h0);
                n = n + 1;
            end
            if (n == 300)
            begin
                miscompares = miscompares + 1;
                test_done;
            end
        end
    endtask

    // Source 0..4 fires a timer overflow, 5 raises the pin
    task pulse(input integer s);
        begin
            @(posedge pclk);
            if (s == 5)
                pin <= 1'h1; // pin is the start input and, under ext_lpt, also holds tracking while low
            else
                fire <= 5'h01 << s;
            @(posedge pclk);
            fire <= 5'h00;
        end
    endtask

    function integer cnt(input [2:0] f);
        begin
            case (f)
                3'h1: cnt = 4;
                3'h2: cnt = 8;
                3'h3: cnt = 16;
                3'h4: cnt = 32;
                3'h5: cnt = 64;
                default: cnt = 1;
            endcase
        end
    endfunction

    // Main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, split, pin, standby} = 7'h00;
        {paddr, pwdata, level, fire} = 55'h0;
        miscompares = 0;
        comparisons = 0;
        // Justify, repeat, code, expected; shift rows keep top justify bit clear
        rows[0] = {3'h0, 3'h0, 10'h3FF, 16'h03FF};
        rows[1] = {3'h4, 3'h0, 10'h3FF, 16'hFFC0};
        rows[2] = {3'h4, 3'h0, 10'h200, 16'h8000};
        rows[3] = {3'h0, 3'h1, 10'h3FF, 16'h0FFC};
        rows[4] = {3'h1, 3'h1, 10'h3FF, 16'h07FE};
        rows[5] = {3'h2, 3'h3, 10'h3FF, 16'h0FFC};
        rows[6] = {3'h3, 3'h5, 10'h3FF, 16'h1FF8};
        rows[7] = {3'h0, 3'h2, 10'h1FF, 16'h0FF8};
        rows[8] = {3'h0, 3'h4, 10'h001, 16'h0020};
        // Mode, timer split, ignored source, starting source
        srcs[0] = {3'h1, 1'h0, 3'h1, 3'h0};
        srcs[1] = {3'h2, 1'h1, 3'h2, 3'h1};
        srcs[2] = {3'h2, 1'h0, 3'h1, 3'h2};
        srcs[3] = {3'h3, 1'h1, 3'h4, 3'h3};
        srcs[4] = {3'h3, 1'h0, 3'h3, 3'h4};
        srcs[5] = {3'h4, 1'h0, 3'h0, 3'h5};
        repeat (12) @(posedge pclk);
        chk({pready, cnv, trk, done}, 4'h8, "rst_out");
        presetn <= 1'h1;
        apb(1'h0, `OFS_CONFIG, 32'h0);
        chk(rd, 32'h1F, "div_rst");
        apb(1'h0, 8'h18, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000, "unmapped");
        // Ratio 3 gives a period of 8 system clocks
        apb(1'h1, `OFS_CONFIG, 32'h3);
        k = 0;
        prv = conversion_clock;
        for (i = 0; i < 80; i = i + 1)
        begin
            @(posedge pclk);
            if (conversion_clock === 1'h1 && prv === 1'h0)
                k = k + 1;
            prv = conversion_clock;
        end
        chk(k, 10, "conversion_clock");
        apb(1'h1, `OFS_CONFIG, 32'h0);
        prev = 16'h0;
        for (i = 0; i < 9; i = i + 1)
        begin
            level <= rows[i][25:16];
            apb(1'h1, `OFS_ACCUM_CFG, {26'h0, rows[i][31:26]});
            for (k = 0; k < cnt(rows[i][28:26]); k = k + 1)
            begin
                apb(1'h1, `OFS_CONTROL, 32'h81);
                poll(0, 1'h0);
                if (k == 0 && rows[i][28:26] != 3'h0)
                begin
                    chk(rd[1], 1'h0, "eoc_mid");
                    apb(1'h0, `OFS_RESULT_LOW, 32'h0);
                    chk(rd, {24'h0, prev[7:0]}, "hold");
                end
            end
            chk(rd[1], 1'h1, "eoc");
            apb(1'h0, `OFS_RESULT_LOW, 32'h0);
            chk(rd, {24'h0, rows[i][7:0]}, "low");
            apb(1'h0, `OFS_RESULT_HIGH, 32'h0);
            chk(rd, {24'h0, rows[i][15:8]}, "high");
            prev = rows[i][15:0];
        end
        chk(trk, 1'h1, "trk_idle");
        standby <= 1'h1;
        repeat (3) @(posedge pclk);
        chk(trk, 1'h0, "standby");
        standby <= 1'h0;
        // Each start source, after a pulse on one that must be ignored
        level <= 10'h2A5;
        apb(1'h1, `OFS_ACCUM_CFG, 32'h0);
        for (i = 0; i < 6; i = i + 1)
        begin
            split <= srcs[i][6];
            apb(1'h1, `OFS_CONTROL, {24'h0, 1'h1, srcs[i][9:7], 4'h0});
            pulse(srcs[i][5:3]);
            repeat (20) @(posedge pclk);
            apb(1'h0, `OFS_CONTROL, 32'h0);
            chk(rd[1:0], 2'h0, "ignored");
            pulse(srcs[i][2:0]);
            poll(1, 1'h1);
            apb(1'h0, `OFS_RESULT_LOW, 32'h0);
            chk(rd, 32'hA5, "src");
        end
        pin <= 1'h0;
        // Low-power tracking: idle off, three ticks of tracking at ratio 0
        apb(1'h1, `OFS_CONTROL, 32'h84);
        repeat (5) @(posedge pclk);
        chk(trk, 1'h0, "lpt_idle");
        apb(1'h1, `OFS_CONTROL, 32'h85);
        k = 0;
        for (n = 0; n < 60 && cnv !== 1'h1; n = n + 1)
        begin
            if (trk === 1'h1)
                k = k + 1;
            @(posedge pclk);
        end
        chk(k, 3, "lpt_trk");
        chk(n < 60, 1'h1, "lpt_cnv");
        if (n == 60)
            test_done;
        poll(0, 1'h0);
        // Pin start in low-power tracking: track while low, convert on rise
        apb(1'h1, `OFS_CONTROL, 32'hC4);
        repeat (8) @(posedge pclk);
        chk(trk, 1'h1, "pin_trk");
        pulse(5);
        poll(1, 1'h1);
        chk(rd[0], 1'h0, "pin_done");
        pin <= 1'h0;
        // Burst of four from one start, idle power per enable bit
        level <= 10'h3FF;
        apb(1'h1, `OFS_ACCUM_CFG, 32'h1);
        for (i = 0; i < 2; i = i + 1)
        begin
            // Start decode uses the mode already held, so configure first
            apb(1'h1, `OFS_CONTROL, {23'h0, 1'h1, i[0], 7'h00});
            apb(1'h1, `OFS_CONTROL, {23'h0, 1'h1, i[0], 7'h01});
            for (n = 0; n < 2000 && done !== 1'h1; n = n + 1)
                @(posedge pclk);
            chk(done, 1'h1, "done");
            if (n == 2000)
                test_done;
            poll(1, 1'h1);
            repeat (4) @(posedge pclk);
            chk(pwr, i[0], "idle_pwr");
            apb(1'h0, `OFS_RESULT_LOW, 32'h0);
            chk(rd, 32'hFC, "burst");
        end
        // Mid-run reset returns divider and control to reset values
        apb(1'h1, `OFS_CONFIG, 32'h5);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, `OFS_CONFIG, 32'h0);
        chk(rd, 32'h1F, "div_rst2");
        apb(1'h0, `OFS_CONTROL, 32'h0);
        chk(rd, 32'h0, "ctl_rst");
        test_done;
    end
endmodule // tb_sar_adc_sequencer
